// ---- common/fpudd_pkg.sv ----
// Shared constants and types of the floating point dispatch and decode block
package fpudd_pkg;

	// Queue and hand-over geometry
	localparam logic [2:0] QUEUE_DEPTH = 3'h4;
	localparam int HANDOVER_CYCLES = 2;

	// Fault vectors raised on a bad memory operand
	localparam logic [7:0] GP_FAULT_VECTOR = 8'h0d;
	localparam logic [7:0] STACK_FAULT_VECTOR = 8'h0c;

	// Escape bytes and fixed second bytes
	localparam logic [7:0] ESC_D8 = 8'hd8;
	localparam logic [7:0] ESC_D9 = 8'hd9;
	localparam logic [7:0] ESC_DA = 8'hda;
	localparam logic [7:0] ESC_DB = 8'hdb;
	localparam logic [7:0] ESC_DC = 8'hdc;
	localparam logic [7:0] ESC_DD = 8'hdd;
	localparam logic [7:0] ESC_DE = 8'hde;
	localparam logic [7:0] ESC_DF = 8'hdf;
	localparam logic [7:0] MODRM_EXP2M1 = 8'hf0;
	localparam logic [7:0] MODRM_ABS = 8'he1;
	localparam logic [7:0] MODRM_CHS = 8'he0;
	localparam logic [7:0] MODRM_CLEX = 8'he2;

	// Clock counts (min/max) per operation
	localparam logic [7:0] CLK_EXP2_MIN = 8'h5c;
	localparam logic [7:0] CLK_EXP2_MAX = 8'h6c;
	localparam logic [7:0] CLK_ABS = 8'h02;
	localparam logic [7:0] CLK_CHS = 8'h02;
	localparam logic [7:0] CLK_ADD_MIN = 8'h04;
	localparam logic [7:0] CLK_ADD_MAX = 8'h09;
	localparam logic [7:0] CLK_IADD_MIN = 8'h08;
	localparam logic [7:0] CLK_IADD_MAX = 8'h0e;
	localparam logic [7:0] CLK_CLEX_WAIT = 8'h05;
	localparam logic [7:0] CLK_CLEX_NOW = 8'h03;
	localparam logic [7:0] CLK_CMOV = 8'h04;
	localparam logic [7:0] CLK_OTHER = 8'h01;

	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
	localparam logic [7:0] REG_EXEC = 8'h10;
	localparam logic [7:0] REG_SAVE = 8'h14;

	// Field positions
	localparam int CTRL_SLOW_BIT = 0;
	localparam int STAT_TOP_LSB = 0;
	localparam int STAT_EXC_BIT = 3;
	localparam int STAT_BUSY_BIT = 4;
	localparam int STAT_HALT_BIT = 5;
	localparam int STAT_QCNT_LSB = 8;
	localparam int SAVE_TOP_LSB = 16;
	localparam int SAVE_CNT_LSB = 20;
	localparam int SAVE_VALID_BIT = 31;
	localparam int IRQ_W = 5;
	localparam int IRQ_GP = 0;
	localparam int IRQ_SS = 1;
	localparam int IRQ_FPEXC = 2;
	localparam int IRQ_OVF = 3;
	localparam int IRQ_DONE = 4;

	// Reset values
	localparam logic [2:0] TOP_RST = 3'h0;
	localparam logic [IRQ_W-1:0] MASK_RST = 5'h00;

	typedef enum logic [4:0] {
		none_op, exp2_minus_one_op, absolute_value_op, real_add_op, real_add_pop_op,
		integer_add_op, sign_flip_op, waiting_exception_clear_op, immediate_exception_clear_op,
		move_if_below_op, move_if_equal_op, move_if_below_equal_op, move_if_unordered_op,
		move_if_not_below_op, move_if_not_equal_op, move_if_above_op, other_op
	} fpudd_op_t;

	typedef enum logic [2:0] {
		mem_none, mem_short_integer, mem_long_integer, mem_quad_integer,
		mem_single_real, mem_double_real, mem_extended_real, mem_packed_bcd
	} fpudd_width_t;

	typedef enum logic [2:0] {EX_IDLE = 3'b001, EX_RUN = 3'b010, EX_HALT = 3'b100} fpudd_ex_state_t;

	typedef struct packed {
		logic [7:0] escape_byte;
		logic [7:0] modrm;
		logic wait_prefix;
		logic carry_flag;
		logic zero_flag;
		logic parity_flag;
	} fpudd_instr_t;

	typedef struct packed {
		fpudd_op_t op;
		fpudd_width_t width;
		logic [2:0] reg_n;
		logic dest_is_n;
		logic pop;
		logic write_en;
		logic clears_exc;
		logic [7:0] clk_min;
		logic [7:0] clk_max;
	} fpudd_dec_t;

	typedef struct packed {
		logic busy;
		logic done;
		fpudd_op_t op;
		fpudd_width_t width;
		logic [2:0] dst_reg;
		logic [2:0] src_reg;
		logic write_en;
		logic pop;
	} fpudd_exec_t;

	typedef struct packed {
		logic valid;
		logic [7:0] vector;
	} fpudd_fault_t;

endpackage

// ---- core/fpudd_decode.sv ----
// Opcode decoder: escape byte and modrm into operation, operand width and clock counts
`timescale 1ns/1ps
module fpudd_decode
	import fpudd_pkg::*;
(
	input wire fpudd_pkg::fpudd_instr_t instr,
	output fpudd_pkg::fpudd_dec_t dec
);
	logic is_reg;
	logic [2:0] sub;

	// Table lookup; unlisted forms keep their width and run as a one cycle generic op
	always_comb begin
		is_reg = (instr.modrm[7:6] == 2'b11);
		sub = instr.modrm[5:3];
		dec = '0;
		dec.op = other_op;
		dec.reg_n = instr.modrm[2:0];
		dec.write_en = 1'b1;
		dec.clk_min = CLK_OTHER;
		dec.clk_max = CLK_OTHER;
		case (instr.escape_byte)
			ESC_D8, ESC_DC: begin
				if (!is_reg) begin
					dec.width = (instr.escape_byte == ESC_DC) ? mem_double_real : mem_single_real;
				end
				if (sub == 3'h0) begin
					dec.op = real_add_op;
					dec.dest_is_n = is_reg && (instr.escape_byte == ESC_DC);
					dec.clk_min = CLK_ADD_MIN;
					dec.clk_max = CLK_ADD_MAX;
				end
			end
			ESC_D9: begin
				if (!is_reg) begin
					dec.width = mem_single_real;
				end else if (instr.modrm == MODRM_EXP2M1) begin
					dec.op = exp2_minus_one_op;
					dec.clk_min = CLK_EXP2_MIN;
					dec.clk_max = CLK_EXP2_MAX;
				end else if (instr.modrm == MODRM_ABS) begin
					dec.op = absolute_value_op;
					dec.clk_min = CLK_ABS;
					dec.clk_max = CLK_ABS;
				end else if (instr.modrm == MODRM_CHS) begin
					dec.op = sign_flip_op;
					dec.clk_min = CLK_CHS;
					dec.clk_max = CLK_CHS;
				end
			end
			ESC_DA, ESC_DE: begin
				if (!is_reg) begin
					dec.width = (instr.escape_byte == ESC_DA) ? mem_long_integer : mem_short_integer;
					if (sub == 3'h0) begin
						dec.op = integer_add_op;
						dec.clk_min = CLK_IADD_MIN;
						dec.clk_max = CLK_IADD_MAX;
					end
				end else if (instr.escape_byte == ESC_DE) begin
					if (sub == 3'h0) begin
						dec.op = real_add_pop_op;
						dec.dest_is_n = 1'b1;
						dec.pop = 1'b1;
						dec.clk_min = CLK_ADD_MIN;
						dec.clk_max = CLK_ADD_MAX;
					end
				end else if (sub[2] == 1'b0) begin
					dec.clk_min = CLK_CMOV;
					dec.clk_max = CLK_CMOV;
					case (sub[1:0])
						2'h0: begin dec.op = move_if_below_op; dec.write_en = instr.carry_flag; end
						2'h1: begin dec.op = move_if_equal_op; dec.write_en = instr.zero_flag; end
						2'h2: begin
							dec.op = move_if_below_equal_op;
							dec.write_en = instr.carry_flag | instr.zero_flag;
						end
						default: begin dec.op = move_if_unordered_op; dec.write_en = instr.parity_flag; end
					endcase
				end
			end
			ESC_DB: begin
				if (!is_reg) begin
					dec.width = (sub == 3'h5 || sub == 3'h7) ? mem_extended_real : mem_long_integer;
				end else if (instr.modrm == MODRM_CLEX) begin
					dec.op = instr.wait_prefix ? waiting_exception_clear_op : immediate_exception_clear_op;
					dec.clears_exc = 1'b1;
					dec.write_en = 1'b0;
					dec.clk_min = instr.wait_prefix ? CLK_CLEX_WAIT : CLK_CLEX_NOW;
					dec.clk_max = dec.clk_min;
				end else if (sub[2:1] == 2'b00 || sub == 3'h2) begin
					dec.clk_min = CLK_CMOV;
					dec.clk_max = CLK_CMOV;
					case (sub[1:0])
						2'h0: begin dec.op = move_if_not_below_op; dec.write_en = ~instr.carry_flag; end
						2'h1: begin dec.op = move_if_not_equal_op; dec.write_en = ~instr.zero_flag; end
						default: begin
							dec.op = move_if_above_op;
							dec.write_en = ~instr.carry_flag & ~instr.zero_flag;
						end
					endcase
				end
			end
			ESC_DD: begin
				dec.width = is_reg ? mem_none : mem_double_real;
			end
			ESC_DF: begin
				if (!is_reg) begin
					dec.width = (sub == 3'h4 || sub == 3'h6) ? mem_packed_bcd :
						((sub == 3'h5 || sub == 3'h7) ? mem_quad_integer : mem_short_integer);
				end
			end
			default: begin
				dec.op = none_op;
				dec.write_en = 1'b0;
			end
		endcase
	end
endmodule

// ---- core/fpudd_top.sv ----
// Floating point dispatch: hand-over stage, pending queue, executor sequencing and registers
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps

module fpudd_top
	import fpudd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic det_valid,
	input wire fpudd_pkg::fpudd_instr_t det_instr,
	input wire logic det_seg_limit_err,
	input wire logic det_access_err,
	input wire logic det_stack_limit_err,
	output logic det_stall,
	input wire logic fp_exception,
	output fpudd_pkg::fpudd_exec_t exec,
	output fpudd_pkg::fpudd_fault_t fault,
	output logic save_valid,
	output logic irq
);
	import fpudd_pkg::*;

	typedef struct packed {
		fpudd_instr_t hand;
		logic hand_v;
		fpudd_instr_t [QUEUE_DEPTH-1:0] queue;
		logic [2:0] q_cnt;
		fpudd_ex_state_t st;
		logic [7:0] cnt;
		fpudd_dec_t dec;
		fpudd_exec_t exec;
		fpudd_fault_t fault;
		logic stall;
		logic save_v;
		logic slow;
		logic [2:0] top;
		logic exc_pend;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		logic [15:0] last_instr;
		logic [15:0] save_instr;
		logic [2:0] save_top;
		logic [2:0] save_cnt;
		logic save_held;
		logic [31:0] rdata;
	} fpudd_state_t;

	fpudd_state_t q;
	fpudd_state_t d;
	fpudd_dec_t head_dec;
	logic deq;
	logic exc_set;
	logic exc_hw_clr;
	logic exc_sw_clr;
	logic others_queued;
	logic [2:0] after_deq;
	logic [IRQ_W-1:0] evt;
	logic [IRQ_W-1:0] irq_w1c;

	// Physical register of operand n, wrapping modulo eight
	function automatic logic [2:0] stack_reg(input logic [2:0] stack_top, input logic [2:0] n);
		logic [3:0] sum;
		sum = {1'b0, stack_top} + {1'b0, n};
		return sum[2:0];
	endfunction

	// Sticky flag update where a new event beats a clear in the same cycle
	function automatic logic [IRQ_W-1:0] sticky(input logic [IRQ_W-1:0] old,
		input logic [IRQ_W-1:0] clr, input logic [IRQ_W-1:0] set);
		return (old & ~clr) | set;
	endfunction

	fpudd_decode u_decode (
		.instr(q.queue[0]),
		.dec(head_dec)
	);

	// Next-state logic for the whole block
	always_comb begin
		d = q;
		deq = 1'b0;
		exc_set = 1'b0;
		exc_hw_clr = 1'b0;
		exc_sw_clr = 1'b0;
		evt = '0;
		irq_w1c = '0;
		d.fault.valid = 1'b0;
		d.exec.done = 1'b0;
		d.save_v = 1'b0;
		d.hand_v = 1'b0;
		d.rdata = '0;

		// Software writes first so the executor's own updates override them
		if (reg_wr) begin
			case (reg_addr)
				REG_CTRL: d.slow = reg_wdata[CTRL_SLOW_BIT];
				REG_STATUS: begin
					d.top = reg_wdata[STAT_TOP_LSB +: 3];
					exc_sw_clr = reg_wdata[STAT_EXC_BIT];
				end
				REG_IRQ_STAT: irq_w1c = reg_wdata[IRQ_W-1:0];
				REG_IRQ_MASK: d.irq_mask = reg_wdata[IRQ_W-1:0];
				default: d.slow = q.slow;
			endcase
		end

		// Executor; a start is held back when an exception arrives in that cycle
		case (q.st)
			EX_IDLE: begin
				if (q.q_cnt != 3'h0 && !fp_exception) begin
					deq = 1'b1;
					d.dec = head_dec;
					d.cnt = q.slow ? head_dec.clk_max : head_dec.clk_min;
					d.st = EX_RUN;
					d.exec.busy = 1'b1;
					d.exec.op = head_dec.op;
					d.exec.width = head_dec.width;
					d.exec.write_en = head_dec.write_en;
					d.exec.pop = head_dec.pop;
					d.last_instr = {q.queue[0].escape_byte, q.queue[0].modrm};
					// Destination is either the stack top or the relative register n
					if (head_dec.dest_is_n) begin
						d.exec.dst_reg = stack_reg(q.top, head_dec.reg_n);
						d.exec.src_reg = q.top;
					end else begin
						d.exec.dst_reg = q.top;
						d.exec.src_reg = stack_reg(q.top, head_dec.reg_n);
					end
				end
			end
			EX_RUN: begin
				// Busy stands for exactly the chosen clock count
				if (q.cnt == 8'h01) begin
					d.st = EX_IDLE;
					d.exec.busy = 1'b0;
					d.exec.done = 1'b1;
					evt[IRQ_DONE] = 1'b1;
					if (q.dec.pop) begin
						d.top = stack_reg(q.top, 3'h1);
					end
					exc_hw_clr = q.dec.clears_exc;
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
			EX_HALT: begin
				// Queue stays frozen until software clears the pending exception
				if (!q.exc_pend) begin
					d.st = EX_IDLE;
				end
			end
			default: d.st = EX_IDLE;
		endcase

		// Queue shift on dequeue, then append the hand-over entry
		after_deq = q.q_cnt - {2'b00, deq};
		if (deq) begin
			for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
				d.queue[i] = q.queue[i+1];
			end
		end
		d.q_cnt = after_deq;
		if (q.hand_v) begin
			d.queue[after_deq[1:0]] = q.hand;
			d.q_cnt = after_deq + 3'h1;
		end

		// Exception with work still pending: snapshot and halt for recovery
		others_queued = (after_deq != 3'h0) || q.hand_v;
		if (fp_exception) begin
			exc_set = 1'b1;
			evt[IRQ_FPEXC] = 1'b1;
			if (others_queued) begin
				d.st = EX_HALT;
				d.exec.busy = 1'b0;
				d.save_v = 1'b1;
				d.save_held = 1'b1;
				d.save_instr = q.last_instr;
				d.save_top = q.top;
				d.save_cnt = d.q_cnt;
			end
		end
		d.exc_pend = (q.exc_pend & ~(exc_sw_clr | exc_hw_clr)) | exc_set;

		// Detection: faults are raised instead of queuing, before anything runs
		if (det_valid) begin
			if (q.stall) begin
				evt[IRQ_OVF] = 1'b1;
			end else if (det_seg_limit_err || det_access_err) begin
				d.fault.valid = 1'b1;
				d.fault.vector = GP_FAULT_VECTOR;
				evt[IRQ_GP] = 1'b1;
			end else if (det_stack_limit_err) begin
				d.fault.valid = 1'b1;
				d.fault.vector = STACK_FAULT_VECTOR;
				evt[IRQ_SS] = 1'b1;
			end else begin
				d.hand = det_instr;
				d.hand_v = 1'b1;
			end
		end

		// Hand-over entry counts toward capacity so the queue cannot overrun
		d.stall = ({1'b0, d.q_cnt} + {3'b000, d.hand_v}) >= {1'b0, QUEUE_DEPTH};

		// Interrupt status and level output
		d.irq_stat = sticky(q.irq_stat, irq_w1c, evt);
		d.irq = |(d.irq_stat & d.irq_mask);

		// Read data valid only in the cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: d.rdata[CTRL_SLOW_BIT] = q.slow;
				REG_STATUS: begin
					d.rdata[STAT_TOP_LSB +: 3] = q.top;
					d.rdata[STAT_EXC_BIT] = q.exc_pend;
					d.rdata[STAT_BUSY_BIT] = q.exec.busy;
					d.rdata[STAT_HALT_BIT] = (q.st == EX_HALT);
					d.rdata[STAT_QCNT_LSB +: 3] = q.q_cnt;
				end
				REG_IRQ_STAT: d.rdata[IRQ_W-1:0] = q.irq_stat;
				REG_IRQ_MASK: d.rdata[IRQ_W-1:0] = q.irq_mask;
				REG_EXEC: begin
					d.rdata[4:0] = q.exec.op;
					d.rdata[10:8] = q.exec.width;
					d.rdata[31:16] = q.last_instr;
				end
				REG_SAVE: begin
					d.rdata[15:0] = q.save_instr;
					d.rdata[SAVE_TOP_LSB +: 3] = q.save_top;
					d.rdata[SAVE_CNT_LSB +: 3] = q.save_cnt;
					d.rdata[SAVE_VALID_BIT] = q.save_held;
				end
				default: d.rdata = '0;
			endcase
		end
	end

	// State register; reset values are constants only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.st <= EX_IDLE;
			q.top <= TOP_RST;
			q.irq_mask <= MASK_RST;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata = q.rdata;
	assign det_stall = q.stall;
	assign exec = q.exec;
	assign fault = q.fault;
	assign save_valid = q.save_v;
	assign irq = q.irq;
endmodule

// ---- dv/fpudd_int_model.sv ----
// Integer unit stand-in that hands instructions to the dispatch block
`timescale 1ns/1ps
module fpudd_int_model
	import fpudd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic go,
	input wire fpudd_pkg::fpudd_instr_t go_instr,
	input wire logic [2:0] go_err,
	input wire logic rude,
	input wire logic det_stall,
	output logic det_valid,
	output fpudd_pkg::fpudd_instr_t det_instr,
	output logic [2:0] det_err,
	output logic pend_q
);
	fpudd_instr_t instr_q;
	logic [2:0] err_q;
	// Offer only while not stalled, unless told to misbehave
	assign det_valid = pend_q && (!det_stall || rude);
	// Idle payload inverted so a stale value never looks current
	assign det_instr = pend_q ? instr_q : ~instr_q;
	assign det_err = pend_q ? err_q : ~err_q;
	// Request held until the edge that takes it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
			instr_q <= '0;
			err_q <= 3'h0;
		end else if (det_valid) begin
			pend_q <= 1'b0;
		end else if (go) begin
			pend_q <= 1'b1;
			instr_q <= go_instr;
			err_q <= go_err;
		end
	end
endmodule

// ---- dv/fpudd_properties.sv ----
// Port-level assertions for the dispatch block
`timescale 1ns/1ps
module fpudd_properties
	import fpudd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic det_valid,
	input wire logic det_seg_limit_err,
	input wire logic det_access_err,
	input wire logic det_stack_limit_err,
	input wire logic det_stall,
	input wire logic fp_exception,
	input wire fpudd_pkg::fpudd_exec_t exec,
	input wire fpudd_pkg::fpudd_fault_t fault,
	input wire logic save_valid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic take;
	logic bad;
	// Accepted hand-over and whether its operand failed the segment limit or access check
	assign take = det_valid && !det_stall;
	assign bad = det_seg_limit_err || det_access_err;
	chk_fault_gp: assert property (
		take && bad |=> fault.valid && fault.vector == GP_FAULT_VECTOR)
		else $error("gp fault missing");
	chk_fault_stack: assert property (
		take && !bad && det_stack_limit_err |=> fault.valid && fault.vector == STACK_FAULT_VECTOR)
		else $error("stack fault missing");
	chk_fault_pulse: assert property (
		fault.valid && !take |=> !fault.valid)
		else $error("fault too long");
	chk_clean_quiet: assert property (
		take && !bad && !det_stack_limit_err |=> !fault.valid)
		else $error("spurious fault");
	chk_refused_quiet: assert property (
		det_valid && det_stall |=> !fault.valid)
		else $error("refused instruction faulted");
	chk_abs_clocks: assert property (
		exec.done && exec.op == absolute_value_op |-> $past(exec.busy) && $past(exec.busy, 2) && !$past(exec.busy, 3))
		else $error("abs length");
	chk_chs_clocks: assert property (
		exec.done && exec.op == sign_flip_op |-> $past(exec.busy) && $past(exec.busy, 2) && !$past(exec.busy, 3))
		else $error("sign flip length");
	chk_pop_done: assert property (
		exec.done && exec.op == real_add_pop_op |-> exec.pop)
		else $error("add pop without pop");
	chk_save_halt: assert property (
		save_valid |-> $past(fp_exception) && !exec.busy)
		else $error("bad snapshot");
endmodule
bind fpudd_top fpudd_properties chk (.clk_sys(clk_sys), .rst_n(rst_n), .det_valid(det_valid),
	.det_seg_limit_err(det_seg_limit_err), .det_access_err(det_access_err),
	.det_stack_limit_err(det_stack_limit_err), .det_stall(det_stall), .fp_exception(fp_exception),
	.exec(exec), .fault(fault), .save_valid(save_valid));

// ---- dv/fpu_dispatch_and_decode_bench.sv ----
// Self-checking bench for the dispatch block
`timescale 1ns/1ps
module fpu_dispatch_and_decode_bench;
	import fpudd_pkg::*;
	logic clk_sys, rst_n, reg_wr, reg_rd, fp_exception, det_stall, save_valid, irq;
	logic go, rude, det_valid, pend;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic [2:0] go_err, det_err;
	fpudd_instr_t go_instr, det_instr;
	fpudd_exec_t exec;
	fpudd_fault_t fault;
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;
	int lat, nb;
	fpudd_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .det_valid(det_valid),
		.det_instr(det_instr), .det_seg_limit_err(det_err[2]), .det_access_err(det_err[1]),
		.det_stack_limit_err(det_err[0]), .det_stall(det_stall), .fp_exception(fp_exception),
		.exec(exec), .fault(fault), .save_valid(save_valid), .irq(irq));
	fpudd_int_model partner (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .go_instr(go_instr),
		.go_err(go_err), .rude(rude), .det_stall(det_stall), .det_valid(det_valid),
		.det_instr(det_instr), .det_err(det_err), .pend_q(pend));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Hang guard, far above the several hundred cycles the run needs
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	task summarize();
		if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task check(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rdr(logic [7:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		rd = reg_rdata;
	endtask
	// Returns at the falling edge just before the taking edge
	task send(logic [7:0] escape_instruction, logic [7:0] m, logic [3:0] f, logic [2:0] e);
		int w;
		@(posedge clk_sys);
		go <= 1'b1;
		go_instr <= {escape_instruction, m, f};
		go_err <= e;
		@(posedge clk_sys);
		go <= 1'b0;
		w = 0;
		@(negedge clk_sys);
		while (!det_valid && w < 300) begin
			@(negedge clk_sys);
			w++;
		end
	endtask
	// Cycles until busy, then busy cycles; ends in the done cycle
	task run();
		lat = 0;
		nb = 0;
		while (!exec.busy && lat < 300) begin
			@(negedge clk_sys);
			lat++;
		end
		while (exec.busy && nb < 300) begin
			@(negedge clk_sys);
			nb++;
		end
	endtask
	task idle();
		int q, w;
		q = 0;
		w = 0;
		while (q < 4 && w < 1000) begin
			@(negedge clk_sys);
			w++;
			q = (exec.busy || pend) ? 0 : q + 1;
		end
	endtask
	task oc(logic [7:0] escape_instruction, logic [7:0] m, logic [3:0] f, fpudd_op_t op, fpudd_width_t wd, int n, logic [1:0] we);
		send(escape_instruction, m, f, 3'h0);
		run();
		check("latency", lat, 3);
		check("done", exec.done, 1'b1);
		check("op", exec.op, op);
		check("clocks", nb, n);
		if (wd != mem_none) check("width", exec.width, wd);
		if (we[1]) check("move taken", exec.write_en, we[0]);
	endtask
	task t_regs();
		rdr(REG_STATUS);
		check("status", rd, 32'h0);
		rdr(8'h20);
		check("unmapped", rd, 32'h0);
		wr(REG_STATUS, 32'h5);
		send(ESC_D9, MODRM_ABS, 4'h0, 3'h0);
		run();
		check("abs dst", exec.dst_reg, 3'h5);
		rdr(REG_IRQ_STAT);
		check("done flag", rd[4], 1'b1);
		check("irq masked", irq, 1'b0);
		wr(REG_IRQ_MASK, 32'h10);
		@(negedge clk_sys);
		check("irq", irq, 1'b1);
		wr(REG_IRQ_STAT, 32'h1f);
		@(negedge clk_sys);
		check("irq clear", irq, 1'b0);
	endtask
	task t_ops();
		// Flags nibble: wait prefix, carry, zero, parity
		oc(8'hd9, 8'hf0, 4'h0, exp2_minus_one_op, mem_none, 92, 2'b00);
		oc(8'hd9, 8'he0, 4'h0, sign_flip_op, mem_none, 2, 2'b00);
		oc(8'hdc, 8'hc1, 4'h0, real_add_op, mem_none, 4, 2'b00);
		check("add dst", exec.dst_reg, 3'h6);
		oc(8'hd8, 8'hc1, 4'h0, real_add_op, mem_none, 4, 2'b00);
		check("add src", exec.src_reg, 3'h6);
		oc(8'hdc, 8'h00, 4'h0, real_add_op, mem_double_real, 4, 2'b00);
		oc(8'hd8, 8'h00, 4'h0, real_add_op, mem_single_real, 4, 2'b00);
		oc(8'hde, 8'hc1, 4'h0, real_add_pop_op, mem_none, 4, 2'b00);
		rdr(REG_STATUS);
		check("pop top", rd[2:0], 3'h6);
		wr(REG_STATUS, 32'h5);
		oc(8'hda, 8'h00, 4'h0, integer_add_op, mem_long_integer, 8, 2'b00);
		oc(8'hde, 8'h00, 4'h0, integer_add_op, mem_short_integer, 8, 2'b00);
		oc(8'hda, 8'hc1, 4'h4, move_if_below_op, mem_none, 4, 2'b11);
		oc(8'hda, 8'hc9, 4'h0, move_if_equal_op, mem_none, 4, 2'b10);
		oc(8'hda, 8'hd1, 4'h2, move_if_below_equal_op, mem_none, 4, 2'b11);
		oc(8'hda, 8'hd9, 4'h1, move_if_unordered_op, mem_none, 4, 2'b11);
		oc(8'hdb, 8'hc1, 4'h4, move_if_not_below_op, mem_none, 4, 2'b10);
		oc(8'hdb, 8'hc9, 4'h0, move_if_not_equal_op, mem_none, 4, 2'b11);
		oc(8'hdb, 8'hd1, 4'h2, move_if_above_op, mem_none, 4, 2'b10);
		wr(REG_CTRL, 32'h1);
		oc(8'hd8, 8'hc1, 4'h0, real_add_op, mem_none, 9, 2'b00);
		rdr(REG_EXEC);
		check("exec reg", rd[31:16], 32'h0000d8c1);
		wr(REG_CTRL, 32'h0);
	endtask
	task t_fault();
		logic [2:0] e [4];
		e = '{3'h4, 3'h2, 3'h1, 3'h5};
		for (int k = 0; k < 4; k++) begin
			send(ESC_D8, 8'h00, 4'h0, e[k]);
			@(negedge clk_sys);
			check("fault", fault.valid, 1'b1);
			check("vector", fault.vector, e[k] == 3'h1 ? STACK_FAULT_VECTOR : GP_FAULT_VECTOR);
			repeat (3) @(negedge clk_sys);
			check("fault exec", exec.busy, 1'b0);
		end
	endtask
	task t_queue();
		send(ESC_D9, MODRM_EXP2M1, 4'h0, 3'h0);
		repeat (4) send(ESC_D8, 8'hc1, 4'h0, 3'h0);
		repeat (3) @(negedge clk_sys);
		check("stall", det_stall, 1'b1);
		rdr(REG_STATUS);
		check("queue", rd[10:8], 3'h4);
		@(posedge clk_sys);
		rude <= 1'b1;
		send(ESC_D9, MODRM_CHS, 4'h0, 3'h0);
		@(posedge clk_sys);
		rude <= 1'b0;
		rdr(REG_IRQ_STAT);
		check("refused flag", rd[3], 1'b1);
		rdr(REG_STATUS);
		check("queue kept", rd[10:8], 3'h4);
		check("exp2 runs", exec.op, exp2_minus_one_op);
		idle();
	endtask
	task t_exc();
		send(ESC_D9, MODRM_EXP2M1, 4'h0, 3'h0);
		send(ESC_D9, MODRM_ABS, 4'h0, 3'h0);
		repeat (6) @(negedge clk_sys);
		@(posedge clk_sys);
		fp_exception <= 1'b1;
		@(posedge clk_sys);
		fp_exception <= 1'b0;
		@(negedge clk_sys);
		check("snapshot", save_valid, 1'b1);
		rdr(REG_SAVE);
		check("saved", rd[31], 1'b1);
		rdr(REG_STATUS);
		check("halted", rd[5:3], 3'h5);
		wr(REG_STATUS, {28'h0, 1'b1, rd[2:0]});
		idle();
		check("resumed", exec.op, absolute_value_op);
		@(posedge clk_sys);
		fp_exception <= 1'b1;
		@(posedge clk_sys);
		fp_exception <= 1'b0;
		@(negedge clk_sys);
		check("no snapshot", save_valid, 1'b0);
		oc(ESC_DB, MODRM_CLEX, 4'h0, immediate_exception_clear_op, mem_none, 3, 2'b00);
		rdr(REG_STATUS);
		check("cleared", rd[3], 1'b0);
		oc(ESC_DB, MODRM_CLEX, 4'h8, waiting_exception_clear_op, mem_none, 5, 2'b00);
	endtask
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		fp_exception = 1'b0;
		go = 1'b0;
		rude = 1'b0;
		go_instr = '0;
		go_err = 3'h0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs();
		t_ops();
		t_fault();
		t_queue();
		t_exc();
		summarize();
	end
endmodule
